// *** src/rtc_calendar.sv ***
// Calendar clock with alarm, event flags and battery-backed storage.
// Assumes a synchronous 32.768 kHz tick and one AHB-Lite master.
// How it works
// - Straps sampled while chip reset held low
// - Clock runs only with enable strap low
// - Fourteen clock bytes plus 114 storage bytes
// - Power failure blocks every byte write
// - Alarm interrupt works on battery power
// - Inhibit bit stops counter to byte transfers
// - One bit picks BCD or binary
// - One bit picks 12 or 24 hours
// - Next update rewrites bytes in current format
// - Seconds and minutes span 0 to 59
// - Binary 12-hour: top bit marks afternoon
// - BCD 12-hour: 01-12 and 81-92
// - 24-hour hours: 00-17h binary, 00-23h BCD
// - Weekday counts 1 to 7, Sunday first
// - Calendar keeps a hundred-year span
// - February gains leap day automatically
// - Optional daylight saving time shift
// - Periodic, alarm and update-ended event flags
// - Enabled event raises request and request flag, update not when inhibited
// - Flag read clears flags, releases interrupt
// - Rate field picks tap; zero disables
// - Alarm compare with top-two-bits don't-care
`timescale 1ns/1ps
module rtc_calendar
  import rtc_calendar_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic chip_reset_n,
  input wire strap_type straps,
  input wire logic main_power_good,
  input wire logic timebase_tick,
  input wire logic clock_chip_select_n,
  input wire ahb_req_type ahb_req,
  input wire logic hready,
  output ahb_rsp_type ahb_rsp,
  output logic square_wave_out,
  output logic irq_n_out,
  output logic irq_drive_n,
  output logic clock_enabled,
  output logic notebook_mode,
  output logic operational_mode
);
  rtc_state_type state_r, state_nxt;
  logic [7:0] ctl_b, rbyte, e_sec, e_min, e_hr;
  logic [6:0] b_sec, b_min, b_yr, n_sec, n_min, n_yr, aidx;
  logic [4:0] b_hr, b_dom, n_hr, n_dom;
  logic [3:0] b_mon, n_mon, rate, expo;
  logic [2:0] b_dow, n_dow;
  logic [DIV_W-1:0] mask;
  logic bin, h24, tick, upd, per, n_fell;
  logic alarm_hit, req, accept, rd_flags;
  acc_kind_type kind;
  function automatic logic [7:0] enc(input logic [6:0] v, input logic b);
    logic [6:0] t;
    logic [6:0] o;
    t = v / 7'd10;
    o = v % 7'd10;
    enc = b ? {1'b0, v} : {t[3:0], o[3:0]};
  endfunction

  function automatic logic [6:0] dec(input logic [7:0] v, input logic b);
    logic [6:0] t;
    t = {3'h0, v[7:4]};
    dec = b ? v[6:0] : 7'(t * 7'd10 + {3'h0, v[3:0]});
  endfunction

  function automatic logic [7:0] enc_hr(input logic [4:0] h,
                                        input logic b, input logic f24);
    logic [4:0] h12;
    logic [7:0] e;
    h12 = (h == 5'd0) ? 5'd12 : ((h > 5'd12) ? 5'(h - 5'd12) : h);
    e = enc({2'h0, h12}, b);
    if (f24) begin
      enc_hr = enc({2'h0, h}, b);
    end else begin
      enc_hr = {(h >= 5'd12), e[6:0]};
    end
  endfunction

  function automatic logic [4:0] dec_hr(input logic [7:0] v,
                                        input logic b, input logic f24);
    logic [6:0] d;
    logic [4:0] h;
    d = dec(f24 ? v : {1'b0, v[6:0]}, b);
    h = d[4:0];
    if (f24) begin
      dec_hr = h;
    end else begin
      dec_hr = 5'(((h == 5'd12) ? 5'd0 : h) + (v[7] ? 5'd12 : 5'd0));
    end
  endfunction

  function automatic logic [4:0] month_days(input logic [3:0] m,
                                            input logic [6:0] y);
    case (m)
      4'd4, 4'd6, 4'd9, 4'd11: month_days = 5'd30;
      4'd2: month_days = (y[1:0] == 2'h0) ? 5'd29 : 5'd28;
      default: month_days = 5'd31;
    endcase
  endfunction

  function automatic logic [3:0] rate_expo(input logic [3:0] c);
    if (c == 4'h0) begin
      rate_expo = 4'h0;
    end else if (c < 4'h3) begin
      rate_expo = 4'(c + 4'h6);
    end else begin
      rate_expo = 4'(c - 4'h1);
    end
  endfunction

  always_comb begin
    state_nxt = state_r;
    if (!chip_reset_n) begin
      state_nxt.clk_en = !straps.clock_enable;
      state_nxt.notebook = !straps.notebook_select;
      state_nxt.operational = straps.operational_select;
    end
    ctl_b = state_r.ram[IDX_CTLB];
    bin = ctl_b[BIT_FORMAT];
    h24 = ctl_b[BIT_HOUR24];
    rate = state_r.ram[IDX_CTLA][3:0];
    expo = rate_expo(rate);
    mask = DIV_W'((16'h0001 << expo) - 16'h0001);
    tick = state_r.clk_en && timebase_tick;
    if (tick) begin
      state_nxt.div = DIV_W'(state_r.div + 1'b1);
    end
    upd = tick && (state_r.div == {DIV_W{1'b1}});
    per = tick && (rate != 4'h0) && ((state_r.div & mask) == mask);
    state_nxt.square = (rate != 4'h0) && ctl_b[BIT_SQUARE_EN] &&
                       (|(state_nxt.div & (mask ^ (mask >> 1))));
    // Pick up host-written time once transfers are allowed
    if (state_r.pending && !ctl_b[BIT_INHIBIT]) begin
      b_sec = dec(state_r.ram[IDX_SEC], bin);
      b_min = dec(state_r.ram[IDX_MIN], bin);
      b_hr = dec_hr(state_r.ram[IDX_HR], bin, h24);
      b_dow = state_r.ram[IDX_DOW][2:0];
      b_dom = 5'(dec(state_r.ram[IDX_DOM], bin));
      b_mon = 4'(dec(state_r.ram[IDX_MON], bin));
      b_yr = dec(state_r.ram[IDX_YR], bin);
    end else begin
      b_sec = state_r.sec;
      b_min = state_r.min;
      b_hr = state_r.hr;
      b_dow = state_r.dow;
      b_dom = state_r.dom;
      b_mon = state_r.mon;
      b_yr = state_r.yr;
    end
    n_sec = b_sec;
    n_min = b_min;
    n_hr = b_hr;
    n_dow = b_dow;
    n_dom = b_dom;
    n_mon = b_mon;
    n_yr = b_yr;
    n_fell = state_r.fell_back;
    if (b_sec < 7'd59) begin
      n_sec = 7'(b_sec + 7'd1);
    end else begin
      n_sec = 7'd0;
      if (b_min < 7'd59) begin
        n_min = 7'(b_min + 7'd1);
      end else begin
        n_min = 7'd0;
        if (ctl_b[BIT_DST_EN] && b_mon == 4'd4 && b_dow == 3'd1 &&
            b_dom <= 5'd7 && b_hr == 5'd1) begin
          n_hr = 5'd3;
        end else if (ctl_b[BIT_DST_EN] && b_mon == 4'd10 &&
                     b_dow == 3'd1 && b_dom >= 5'd25 && b_hr == 5'd1 &&
                     !state_r.fell_back) begin
          n_hr = 5'd1;
          n_fell = 1'b1;
        end else if (b_hr < 5'd23) begin
          n_hr = 5'(b_hr + 5'd1);
          n_fell = 1'b0;
        end else begin
          n_hr = 5'd0;
          n_dow = (b_dow >= 3'd7) ? 3'd1 : 3'(b_dow + 3'd1);
          if (b_dom < month_days(b_mon, b_yr)) begin
            n_dom = 5'(b_dom + 5'd1);
          end else begin
            n_dom = 5'd1;
            if (b_mon < 4'd12) begin
              n_mon = 4'(b_mon + 4'd1);
            end else begin
              n_mon = 4'd1;
              n_yr = (b_yr >= 7'd99) ? 7'd0 : 7'(b_yr + 7'd1);
            end
          end
        end
      end
    end
    e_sec = enc(n_sec, bin);
    e_min = enc(n_min, bin);
    e_hr = enc_hr(n_hr, bin, h24);
    alarm_hit = (state_r.ram[IDX_SEC_ALM][7:6] == 2'h3 ||
                 state_r.ram[IDX_SEC_ALM] == e_sec) &&
                (state_r.ram[IDX_MIN_ALM][7:6] == 2'h3 ||
                 state_r.ram[IDX_MIN_ALM] == e_min) &&
                (state_r.ram[IDX_HR_ALM][7:6] == 2'h3 ||
                 state_r.ram[IDX_HR_ALM] == e_hr);
    if (upd) begin
      state_nxt.sec = n_sec;
      state_nxt.min = n_min;
      state_nxt.hr = n_hr;
      state_nxt.dow = n_dow;
      state_nxt.dom = n_dom;
      state_nxt.mon = n_mon;
      state_nxt.yr = n_yr;
      state_nxt.fell_back = n_fell;
      if (!ctl_b[BIT_INHIBIT]) begin
        state_nxt.pending = 1'b0;
        state_nxt.ram[IDX_SEC] = e_sec;
        state_nxt.ram[IDX_MIN] = e_min;
        state_nxt.ram[IDX_HR] = e_hr;
        state_nxt.ram[IDX_DOW] = {5'h00, n_dow};
        state_nxt.ram[IDX_DOM] = enc({2'h0, n_dom}, bin);
        state_nxt.ram[IDX_MON] = enc({3'h0, n_mon}, bin);
        state_nxt.ram[IDX_YR] = enc(n_yr, bin);
      end
    end
    // Data phase of a write
    if (state_r.wr_pend && state_r.clk_en) begin
      if (state_r.wr_kind == ACC_INDEX) begin
        state_nxt.idx = ahb_req.hwdata[6:0];
      end else if (state_r.wr_kind == ACC_BYTE && main_power_good) begin
        if (state_r.wr_idx == IDX_CTLA) begin
          state_nxt.ram[IDX_CTLA] = {1'b0, ahb_req.hwdata[6:0]};
        end else if (state_r.wr_idx != IDX_FLAGS &&
                     state_r.wr_idx != IDX_POWER) begin
          state_nxt.ram[state_r.wr_idx] = ahb_req.hwdata[7:0];
        end
        if (state_r.wr_idx == IDX_SEC || state_r.wr_idx == IDX_MIN ||
            state_r.wr_idx == IDX_HR ||
            (state_r.wr_idx >= IDX_DOW && state_r.wr_idx <= IDX_YR)) begin
          state_nxt.pending = 1'b1;
        end
      end
    end
    // Address phase
    accept = ahb_req.hsel && ahb_req.htrans[1] && hready &&
             !clock_chip_select_n;
    if (ahb_req.haddr[31:9] == 23'h0) begin
      kind = ACC_BYTE;
      aidx = ahb_req.haddr[8:2];
    end else if (ahb_req.haddr == ADDR_INDEX_PORT) begin
      kind = ACC_INDEX;
      aidx = state_nxt.idx;
    end else if (ahb_req.haddr == ADDR_DATA_PORT) begin
      kind = ACC_BYTE;
      aidx = state_nxt.idx;
    end else begin
      kind = ACC_NONE;
      aidx = 7'h00;
    end
    if (kind == ACC_INDEX) begin
      rbyte = {1'b0, state_nxt.idx};
    end else if (aidx == IDX_POWER) begin
      rbyte = {main_power_good, 7'h00};
    end else begin
      rbyte = state_nxt.ram[aidx];
    end
    rd_flags = accept && !ahb_req.hwrite && kind == ACC_BYTE &&
               aidx == IDX_FLAGS && state_r.clk_en;
    state_nxt.wr_pend = accept && ahb_req.hwrite;
    state_nxt.wr_kind = accept ? kind : ACC_NONE;
    state_nxt.wr_idx = aidx;
    if (accept && !ahb_req.hwrite) begin
      state_nxt.rdata = (kind == ACC_NONE || !state_r.clk_en) ? 32'h0 :
                        {24'h000000, rbyte};
    end
    if (rd_flags) begin
      state_nxt.ram[IDX_FLAGS] = BYTE_RST;
    end
    // Event sets come last so a same-cycle read cannot lose them
    req = (per && ctl_b[BIT_PERIODIC_EN]) ||
          (upd && alarm_hit && ctl_b[BIT_ALARM_EN]) ||
          (upd && ctl_b[BIT_UPDATE_EN] && !ctl_b[BIT_INHIBIT]);
    if (per) begin
      state_nxt.ram[IDX_FLAGS][BIT_PERIODIC_FLAG] = 1'b1;
    end
    if (upd) begin
      state_nxt.ram[IDX_FLAGS][BIT_UPDATE_FLAG] = 1'b1;
    end
    if (upd && alarm_hit) begin
      state_nxt.ram[IDX_FLAGS][BIT_ALARM_FLAG] = 1'b1;
    end
    if (req) begin
      state_nxt.ram[IDX_FLAGS][BIT_IRQ_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= '0;
      state_r.dow <= DOW_RST;
      state_r.dom <= DOM_RST;
      state_r.mon <= MON_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign ahb_rsp.hrdata = state_r.rdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp = 1'b0;
  assign square_wave_out = state_r.square;
  assign irq_n_out = 1'b0;
  assign irq_drive_n = !state_r.ram[IDX_FLAGS][BIT_IRQ_FLAG];
  assign clock_enabled = state_r.clk_en;
  assign notebook_mode = state_r.notebook;
  assign operational_mode = state_r.operational;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence seq_enabled_update;
    upd && ctl_b[BIT_UPDATE_EN] && !ctl_b[BIT_INHIBIT];
  endsequence
  sequence seq_irq_raised;
    state_r.ram[IDX_FLAGS][BIT_IRQ_FLAG] && !irq_drive_n;
  endsequence

  AST_STRAP_SAMPLE: assert property (
    !chip_reset_n |=> clock_enabled == !$past(straps.clock_enable))
    else $error("strap not captured during chip reset");
  AST_NO_RUN_DISABLED: assert property (
    !state_r.clk_en |-> !upd && !per ##1 $stable(state_r.ram))
    else $error("clock ran while disabled");
  AST_POWER_BLOCK: assert property (
    state_r.wr_pend && state_r.wr_kind == ACC_BYTE && !main_power_good &&
    !upd && state_r.wr_idx > IDX_FLAGS |=>
    state_r.ram[$past(state_r.wr_idx)] ==
    $past(state_r.ram[state_r.wr_idx]))
    else $error("write landed during power failure");
  AST_INHIBIT_HOLD: assert property (
    upd && ctl_b[BIT_INHIBIT] && !state_r.wr_pend |=>
    $stable(state_r.ram[IDX_SEC]))
    else $error("transfer happened while inhibited");
  AST_TIME_RANGE: assert property (
    state_r.sec <= 7'd59 && state_r.min <= 7'd59)
    else $error("seconds or minutes out of range");
  AST_HOUR_RANGE: assert property (
    state_r.hr <= 5'd23)
    else $error("hour out of range");
  AST_WEEKDAY_RANGE: assert property (
    state_r.dow >= 3'd1 && state_r.dow <= 3'd7)
    else $error("weekday out of range");
  AST_UPDATE_IRQ: assert property (
    seq_enabled_update |=> seq_irq_raised)
    else $error("enabled update did not raise request");
  AST_READ_CLEAR: assert property (
    rd_flags && !per && !upd |=>
    state_r.ram[IDX_FLAGS][7:4] == 4'h0 && irq_drive_n)
    else $error("flag read did not clear");
  AST_RATE_OFF: assert property (
    rate == 4'h0 |-> !per ##1 !square_wave_out)
    else $error("rate zero still produced events");
  AST_ALARM_FLAG: assert property (
    upd && alarm_hit |=> state_r.ram[IDX_FLAGS][BIT_ALARM_FLAG])
    else $error("alarm match missed");
endmodule // rtc_calendar

// *** src/rtc_calendar_pkg.sv ***
// Constants, register map and carrier types of the calendar clock.
// Assumes one AHB-Lite master and a 32.768 kHz tick in the bus domain.
package rtc_calendar_pkg;
  localparam int CLOCK_BYTES = 14;
  localparam int STORE_BYTES = 114;
  localparam int REG_BYTES = CLOCK_BYTES + STORE_BYTES;
  localparam int DIV_W = 15;

  // Byte indices; byte address is four times the index
  localparam logic [6:0] IDX_SEC = 7'h00;
  localparam logic [6:0] IDX_SEC_ALM = 7'h01;
  localparam logic [6:0] IDX_MIN = 7'h02;
  localparam logic [6:0] IDX_MIN_ALM = 7'h03;
  localparam logic [6:0] IDX_HR = 7'h04;
  localparam logic [6:0] IDX_HR_ALM = 7'h05;
  localparam logic [6:0] IDX_DOW = 7'h06;
  localparam logic [6:0] IDX_DOM = 7'h07;
  localparam logic [6:0] IDX_MON = 7'h08;
  localparam logic [6:0] IDX_YR = 7'h09;
  localparam logic [6:0] IDX_CTLA = 7'h0a;
  localparam logic [6:0] IDX_CTLB = 7'h0b;
  localparam logic [6:0] IDX_FLAGS = 7'h0c;
  localparam logic [6:0] IDX_POWER = 7'h0d;
  localparam logic [31:0] ADDR_INDEX_PORT = 32'h0000_0200;
  localparam logic [31:0] ADDR_DATA_PORT = 32'h0000_0204;

  // Control byte B, flag byte C, power byte D
  localparam int BIT_INHIBIT = 7;
  localparam int BIT_PERIODIC_EN = 6;
  localparam int BIT_ALARM_EN = 5;
  localparam int BIT_UPDATE_EN = 4;
  localparam int BIT_SQUARE_EN = 3;
  localparam int BIT_FORMAT = 2;
  localparam int BIT_HOUR24 = 1;
  localparam int BIT_DST_EN = 0;
  localparam int BIT_IRQ_FLAG = 7;
  localparam int BIT_PERIODIC_FLAG = 6;
  localparam int BIT_ALARM_FLAG = 5;
  localparam int BIT_UPDATE_FLAG = 4;
  localparam int BIT_POWER_OK = 7;

  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] DOW_RST = 3'h1;
  localparam logic [4:0] DOM_RST = 5'h01;
  localparam logic [3:0] MON_RST = 4'h1;

  typedef enum logic [1:0] {ACC_NONE, ACC_BYTE, ACC_INDEX} acc_kind_type;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
  } ahb_req_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_type;

  typedef struct packed {
    logic notebook_select;
    logic operational_select;
    logic clock_enable;
  } strap_type;

  typedef struct packed {
    logic [REG_BYTES-1:0][7:0] ram;
    logic [6:0] sec;
    logic [6:0] min;
    logic [4:0] hr;
    logic [2:0] dow;
    logic [4:0] dom;
    logic [3:0] mon;
    logic [6:0] yr;
    logic pending;
    logic fell_back;
    logic [DIV_W-1:0] div;
    logic square;
    logic [6:0] idx;
    logic wr_pend;
    acc_kind_type wr_kind;
    logic [6:0] wr_idx;
    logic [31:0] rdata;
    logic clk_en;
    logic notebook;
    logic operational;
  } rtc_state_type;
endpackage

// *** verification/host_bus_model.sv ***
// Host model: single-word AHB-Lite master with a qualified chip select.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module host_bus_model
  import rtc_calendar_pkg::*;
(
  input wire logic clock,
  input wire ahb_rsp_type rsp,
  output ahb_req_type req,
  output logic select_n
);
  initial begin
    req = '{hsel: 1'b1, haddr: 32'h0, htrans: 2'b00, hwrite: 1'b0,
      hsize: 3'h2, hwdata: 32'h0};
    select_n = 1'b1;
  end

  // Select low only across both phases of a transfer
  task automatic xfer(input logic wr, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    req.haddr <= a;
    req.htrans <= 2'b10;
    req.hwrite <= wr;
    select_n <= 1'b0;
    do @(posedge clock); while (rsp.hreadyout !== 1'b1);
    req.htrans <= 2'b00;
    req.hwdata <= d;
    do @(posedge clock); while (rsp.hreadyout !== 1'b1);
    q = rsp.hrdata;
    req.hwdata <= ~d;
    req.haddr <= ~a;
    select_n <= 1'b1;
  endtask
endmodule // host_bus_model

// *** verification/testbench.sv ***
// Testbench: straps, byte access, power fail, updates, periodic events.
// Assumes the calendar clock design and the host bus model.
`timescale 1ns/1ps
module testbench;
  import rtc_calendar_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic chip_reset_n = 1'b0;
  strap_type straps = 3'b010;
  logic main_power_good = 1'b1;
  logic timebase_tick = 1'b0;
  logic clock_chip_select_n;
  ahb_req_type ahb_req;
  ahb_rsp_type ahb_rsp;
  logic square_wave_out;
  logic irq_drive_n;
  logic irq_n_out;
  logic clock_enabled;
  logic notebook_mode;
  logic operational_mode;
  logic sq_high = 1'b0;
  logic [31:0] q;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  always #4 clock = ~clock;

  rtc_calendar dut (.clock(clock), .nrst(nrst),
    .chip_reset_n(chip_reset_n), .straps(straps),
    .main_power_good(main_power_good), .timebase_tick(timebase_tick),
    .clock_chip_select_n(clock_chip_select_n), .ahb_req(ahb_req),
    .hready(ahb_rsp.hreadyout), .ahb_rsp(ahb_rsp),
    .square_wave_out(square_wave_out), .irq_n_out(irq_n_out),
    .irq_drive_n(irq_drive_n), .clock_enabled(clock_enabled),
    .notebook_mode(notebook_mode), .operational_mode(operational_mode));

  host_bus_model host (.clock(clock), .rsp(ahb_rsp), .req(ahb_req),
    .select_n(clock_chip_select_n));

  task automatic print_verdict();
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    host.xfer(1'b1, {23'h0, i, 2'b00}, {24'h0, d}, q);
  endtask

  task automatic rd(input logic [6:0] i);
    host.xfer(1'b0, {23'h0, i, 2'b00}, 32'h0, q);
  endtask

  // One tick per cycle, then two quiet cycles
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      timebase_tick <= 1'b1;
      sq_high = sq_high | square_wave_out;
    end
    @(posedge clock);
    timebase_tick <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic do_reset(input strap_type s);
    @(posedge clock);
    nrst <= 1'b0;
    chip_reset_n <= 1'b0;
    straps <= s;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    chip_reset_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask

  task automatic test_straps();
    do_reset(3'b101);
    check("clock_enabled off", {31'h0, clock_enabled}, 32'h0);
    check("notebook off", {31'h0, notebook_mode}, 32'h0);
    check("operational off", {31'h0, operational_mode}, 32'h0);
    wr(7'h0e, 8'h77);
    rd(7'h0e);
    check("disabled byte", q, 32'h0);
    do_reset(3'b010);
    check("clock_enabled on", {31'h0, clock_enabled}, 32'h1);
    check("notebook on", {31'h0, notebook_mode}, 32'h1);
    check("operational on", {31'h0, operational_mode}, 32'h1);
    $display("Test straps done");
  endtask

  task automatic test_access();
    wr(7'h0e, 8'ha5);
    wr(7'h7f, 8'h5a);
    rd(7'h0e);
    check("byte 14", q, 32'ha5);
    rd(7'h7f);
    check("byte 127", q, 32'h5a);
    host.xfer(1'b1, ADDR_INDEX_PORT, 32'h7f, q);
    host.xfer(1'b0, ADDR_INDEX_PORT, 32'h0, q);
    check("index port", q, 32'h7f);
    host.xfer(1'b0, ADDR_DATA_PORT, 32'h0, q);
    check("data port read", q, 32'h5a);
    host.xfer(1'b1, ADDR_DATA_PORT, 32'h3c, q);
    rd(7'h7f);
    check("data port write", q, 32'h3c);
    wr(IDX_FLAGS, 8'hff);
    rd(IDX_FLAGS);
    check("flags read-only", q, 32'h0);
    host.xfer(1'b0, 32'h300, 32'h0, q);
    check("unmapped", q, 32'h0);
    check("response okay", {31'h0, ahb_rsp.hresp}, 32'h0);
    main_power_good <= 1'b0;
    wr(7'h0e, 8'h11);
    rd(7'h0e);
    check("write in power fail", q, 32'ha5);
    rd(IDX_POWER);
    check("power byte low", q, 32'h0);
    main_power_good <= 1'b1;
    rd(IDX_POWER);
    check("power byte high", q, 32'h80);
    $display("Test access done");
  endtask

  task automatic test_update();
    logic [6:0] ci [7] = '{IDX_SEC, IDX_MIN, IDX_HR, IDX_DOW, IDX_DOM,
      IDX_MON, IDX_YR};
    logic [7:0] set [7] = '{8'h59, 8'h59, 8'h91, 8'h07, 8'h28, 8'h02, 8'h00};
    logic [7:0] exp [7] = '{8'h00, 8'h00, 8'h12, 8'h01, 8'h29, 8'h02, 8'h00};
    wr(IDX_CTLB, 8'h92);
    wr(IDX_CTLA, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(ci[i], set[i]);
    end
    wr(IDX_SEC_ALM, 8'h01);
    wr(IDX_MIN_ALM, 8'h00);
    wr(IDX_HR_ALM, 8'h00);
    rd(IDX_FLAGS);
    tick(32768);
    check("no request inhibited", {31'h0, irq_drive_n}, 32'h1);
    rd(IDX_FLAGS);
    check("inhibited flags", q & 32'hb0, 32'h30);
    rd(IDX_SEC);
    check("seconds frozen", q, 32'h59);
    wr(IDX_SEC_ALM, 8'h00);
    wr(IDX_MIN_ALM, 8'hc0);
    wr(IDX_HR_ALM, 8'hc0);
    wr(IDX_CTLB, 8'h30);
    main_power_good <= 1'b0;
    for (int n = 0; n < 32800; n++) begin
      @(posedge clock);
      if (irq_drive_n === 1'b0) break;
      timebase_tick <= 1'b1;
    end
    @(posedge clock);
    timebase_tick <= 1'b0;
    main_power_good <= 1'b1;
    repeat (2) @(posedge clock);
    check("request on battery", {31'h0, irq_drive_n}, 32'h0);
    check("irq pin level", {31'h0, irq_n_out}, 32'h0);
    rd(IDX_FLAGS);
    check("update flags", q, 32'hb0);
    check("irq released", {31'h0, irq_drive_n}, 32'h1);
    rd(IDX_FLAGS);
    check("flags cleared", q, 32'h0);
    for (int i = 0; i < 7; i++) begin
      rd(ci[i]);
      check("calendar byte", q, {24'h0, exp[i]});
    end
    $display("Test update done");
  endtask

  task automatic test_periodic();
    int per;
    wr(IDX_CTLB, 8'h08);
    for (int c = 0; c < 9; c++) begin
      per = (c == 0) ? 256 : (c < 3) ? 2 ** (c + 6) : 2 ** (c - 1);
      wr(IDX_CTLA, c[7:0]);
      rd(IDX_FLAGS);
      sq_high = 1'b0;
      tick(per);
      rd(IDX_FLAGS);
      check("periodic flag", q & 32'h40, (c == 0) ? 32'h0 : 32'h40);
      check("square wave", {31'h0, sq_high}, {31'h0, c != 0});
    end
    wr(IDX_CTLB, 8'h48);
    wr(IDX_CTLA, 8'h03);
    rd(IDX_FLAGS);
    tick(4);
    check("periodic request", {31'h0, irq_drive_n}, 32'h0);
    rd(IDX_FLAGS);
    check("periodic flags", q, 32'hc0);
    $display("Test periodic done");
  endtask

  initial begin
    test_straps();
    test_access();
    test_update();
    test_periodic();
    print_verdict();
  end
endmodule // testbench
